// ---- src/nvs_host.sv ----
// Host controller driving a nonvolatile SRAM: accesses, store and recall
module nvs_host #(
	parameter int unsigned STORE_CYC   = nvs_pkg::STORE_CYC,
	parameter int unsigned RECALL_CYC  = nvs_pkg::RECALL_CYC,
	parameter int unsigned RESTORE_CYC = nvs_pkg::RESTORE_CYC
) (
	input  wire logic            i_core_clk,
	input  wire logic            i_sys_rst,
	input  wire logic            i_req,
	input  wire nvs_pkg::nvs_op_t i_op,
	input  wire logic [12:0]     i_addr,
	input  wire logic [7:0]      i_wdata,
	output logic                 o_ready,
	output logic                 o_done,
	output logic [7:0]           o_rdata,
	output logic [12:0]          o_mem_addr,
	output logic                 o_cs_n,
	output logic                 o_dir_sel_n,
	output logic                 o_oe_n,
	output logic [7:0]           o_dq_out,
	output logic                 o_dq_oe,
	input  wire logic [7:0]      i_dq_in
);
	typedef enum logic [2:0] {
		M_PWR  = 3'b000,
		M_IDLE = 3'b001,
		M_ACC  = 3'b010,
		M_SEQ  = 3'b011,
		M_WAIT = 3'b100
	} nvs_mst_t;

	nvs_cyc_if cif ();

	nvs_mst_t                     state;
	nvs_mst_t                     next_state;
	nvs_pkg::nvs_op_t             op;
	logic [12:0]                  addr_q;
	logic [7:0]                   wdata_q;
	logic [2:0]                   idx;
	logic [nvs_pkg::WAIT_W-1:0]   cnt;
	logic                         start;

	wire seq_last = (idx == nvs_pkg::SEQ_LAST);
	wire [nvs_pkg::WAIT_W-1:0] pwr_end  = nvs_pkg::WAIT_W'(RESTORE_CYC - 1);
	wire [nvs_pkg::WAIT_W-1:0] st_end   = nvs_pkg::WAIT_W'(STORE_CYC - 1);
	wire [nvs_pkg::WAIT_W-1:0] rc_end   = nvs_pkg::WAIT_W'(RECALL_CYC - 1);
	wire [nvs_pkg::WAIT_W-1:0] wait_end = (op == nvs_pkg::OP_STORE) ? st_end : rc_end;
	wire [nvs_pkg::WAIT_W-1:0] cnt_end  = (state == M_PWR) ? pwr_end : wait_end;
	wire cnt_hit = (cnt == cnt_end);
	// fixed trigger address table, last entry picks store or recall
	wire [12:0] tail_addr = (op == nvs_pkg::OP_STORE) ? nvs_pkg::SEQ_STORE : nvs_pkg::SEQ_RECALL;
	wire [12:0] seq_addr  = (idx == 3'h0) ? nvs_pkg::SEQ_A0 :
		(idx == 3'h1) ? nvs_pkg::SEQ_A1 :
		(idx == 3'h2) ? nvs_pkg::SEQ_A2 :
		(idx == 3'h3) ? nvs_pkg::SEQ_A3 :
		(idx == 3'h4) ? nvs_pkg::SEQ_A4 : tail_addr;

	// trigger accesses are reads with output enable left high
	assign cif.start    = start;
	assign cif.is_write = (state == M_ACC) && (op == nvs_pkg::OP_WRITE);
	assign cif.oe_en    = (state == M_ACC);
	assign cif.addr     = (state == M_SEQ) ? seq_addr : addr_q;
	assign cif.wdata    = wdata_q;

	nvs_cyc u_cyc (
		.i_core_clk  (i_core_clk),
		.i_sys_rst   (i_sys_rst),
		.cif         (cif),
		.o_mem_addr  (o_mem_addr),
		.o_cs_n      (o_cs_n),
		.o_dir_sel_n (o_dir_sel_n),
		.o_oe_n      (o_oe_n),
		.o_dq_out    (o_dq_out),
		.o_dq_oe     (o_dq_oe),
		.i_dq_in     (i_dq_in)
	);

	always_comb begin
		next_state = state;
		unique case (state)
			// strobes stay high until the power-up recall has surely ended
			M_PWR:  if (cnt_hit) next_state = M_IDLE;
			M_IDLE: if (i_req) next_state = i_op[1] ? M_SEQ : M_ACC;
			M_ACC:  if (cif.done) next_state = M_IDLE;
			// nothing else is issued until all six reads are out
			M_SEQ:  if (cif.done && seq_last) next_state = M_WAIT;
			// bus left idle for the full store or recall time
			M_WAIT: if (cnt_hit) next_state = M_IDLE;
			default: next_state = M_PWR;
		endcase
	end

	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			state   <= M_PWR;
			op      <= nvs_pkg::OP_READ;
			addr_q  <= 13'h0000;
			wdata_q <= 8'h00;
			idx     <= 3'h0;
			cnt     <= '0;
			start   <= 1'h0;
			o_ready <= 1'h0;
			o_done  <= 1'h0;
			o_rdata <= 8'h00;
		end else begin
			state   <= next_state;
			o_ready <= (next_state == M_IDLE);
			o_done  <= (cif.done && state == M_ACC) || (state == M_WAIT && cnt_hit);
			cnt     <= (next_state != state) ? '0 : cnt + 1'h1;
			start   <= (state == M_IDLE && i_req) || (state == M_SEQ && cif.done && !seq_last);
			if (state == M_IDLE && i_req) begin
				op      <= i_op;
				addr_q  <= i_addr;
				wdata_q <= i_wdata;
				idx     <= 3'h0;
			end
			if (state == M_SEQ && cif.done)
				idx <= idx + 3'h1;
			if (state == M_ACC && cif.done && op == nvs_pkg::OP_READ)
				o_rdata <= cif.rdata;
		end
	end

	// Counts real chip select falls, so the checks see the pin sequence, not idx
	logic [2:0] fall_cnt;
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst || state == M_IDLE)
			fall_cnt <= 3'h0;
		else if (state == M_SEQ && $fell(o_cs_n))
			fall_cnt <= fall_cnt + 3'h1;
	end

	wire [12:0] ord_addr = (fall_cnt == 3'h0) ? nvs_pkg::SEQ_A0 :
		(fall_cnt == 3'h1) ? nvs_pkg::SEQ_A1 :
		(fall_cnt == 3'h2) ? nvs_pkg::SEQ_A2 :
		(fall_cnt == 3'h3) ? nvs_pkg::SEQ_A3 : nvs_pkg::SEQ_A4;

	property p_six_reads;
		@(posedge i_core_clk) disable iff (i_sys_rst)
		(state == M_SEQ && next_state == M_WAIT) |-> (fall_cnt == 3'h6);
	endproperty
	a_six_reads: assert property (p_six_reads) else $error("trigger not six reads");

	property p_tail_addr;
		@(posedge i_core_clk) disable iff (i_sys_rst)
		(state == M_SEQ && $fell(o_cs_n) && fall_cnt == 3'h5) |->
			o_mem_addr == ((op == nvs_pkg::OP_STORE) ? 13'h0F0F : 13'h0F0E);
	endproperty
	a_tail_addr: assert property (p_tail_addr) else $error("wrong sixth trigger address");

	property p_seq_reads;
		@(posedge i_core_clk) disable iff (i_sys_rst)
		(state == M_SEQ) |-> o_dir_sel_n;
	endproperty
	a_seq_reads: assert property (p_seq_reads) else $error("write inside trigger");

	property p_pwr_quiet;
		@(posedge i_core_clk) disable iff (i_sys_rst)
		(state == M_PWR) |-> (o_cs_n && o_dir_sel_n && !o_ready);
	endproperty
	a_pwr_quiet: assert property (p_pwr_quiet) else $error("bus active in power-up");

	property p_seq_order;
		@(posedge i_core_clk) disable iff (i_sys_rst)
		(state == M_SEQ && $fell(o_cs_n) && fall_cnt < 3'h5) |-> (o_mem_addr == ord_addr);
	endproperty
	a_seq_order: assert property (p_seq_order) else $error("trigger address out of order");

	// Trigger reads discard their data, so the lane is never turned round
	property p_seq_oe;
		@(posedge i_core_clk) disable iff (i_sys_rst)
		(state == M_SEQ) |-> o_oe_n;
	endproperty
	a_seq_oe: assert property (p_seq_oe) else $error("output enable low in trigger");

	property p_wait_quiet;
		@(posedge i_core_clk) disable iff (i_sys_rst)
		(state == M_WAIT) |-> (o_cs_n && !o_ready && cnt <= cnt_end);
	endproperty
	a_wait_quiet: assert property (p_wait_quiet) else $error("bus active in wait");

	property p_done_pulse;
		@(posedge i_core_clk) disable iff (i_sys_rst)
		o_done |-> (o_ready && state == M_IDLE) ##1 !o_done;
	endproperty
	a_done_pulse: assert property (p_done_pulse) else $error("done not one pulse");

	property p_ready_idle;
		@(posedge i_core_clk) disable iff (i_sys_rst)
		o_ready |-> (state == M_IDLE && o_cs_n && !o_dq_oe);
	endproperty
	a_ready_idle: assert property (p_ready_idle) else $error("ready while bus busy");

	c_store:  cover property (@(posedge i_core_clk) disable iff (i_sys_rst)
		state == M_WAIT && op == nvs_pkg::OP_STORE && cnt_hit);
	c_recall: cover property (@(posedge i_core_clk) disable iff (i_sys_rst)
		state == M_WAIT && op == nvs_pkg::OP_RECALL && cnt_hit);
	c_read:   cover property (@(posedge i_core_clk) disable iff (i_sys_rst)
		o_done && op == nvs_pkg::OP_READ);
endmodule

// ---- src/nvs_pkg.sv ----
// Shared constants and types for the nonvolatile SRAM host controller
package nvs_pkg;
	localparam int unsigned ADDR_W      = 13;
	localparam int unsigned DATA_W      = 8;
	localparam int unsigned WAIT_W      = 22;
	localparam int unsigned CLK_NS      = 4;
	// Slowest speed grade, so any fitted part is served
	localparam int unsigned RD_ACC_NS   = 55;
	localparam int unsigned WR_PULSE_NS = 45;
	localparam int unsigned STORE_MS    = 10;
	localparam int unsigned RECALL_US   = 20;
	localparam int unsigned RESTORE_US  = 550;
	localparam int unsigned RD_CYC      = (RD_ACC_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned WR_CYC      = (WR_PULSE_NS + CLK_NS - 1) / CLK_NS;
	// Pin data passes a two-stage synchroniser before it is sampled
	localparam int unsigned SYNC_CYC    = 2;
	localparam int unsigned STORE_CYC   = (STORE_MS * 1000000 + CLK_NS - 1) / CLK_NS;
	localparam int unsigned RECALL_CYC  = (RECALL_US * 1000 + CLK_NS - 1) / CLK_NS;
	localparam int unsigned RESTORE_CYC = (RESTORE_US * 1000 + CLK_NS - 1) / CLK_NS;
	localparam logic [12:0] SEQ_A0      = 13'h0000;
	localparam logic [12:0] SEQ_A1      = 13'h1555;
	localparam logic [12:0] SEQ_A2      = 13'h0AAA;
	localparam logic [12:0] SEQ_A3      = 13'h1FFF;
	localparam logic [12:0] SEQ_A4      = 13'h10F0;
	localparam logic [12:0] SEQ_STORE   = 13'h0F0F;
	localparam logic [12:0] SEQ_RECALL  = 13'h0F0E;
	localparam logic [2:0]  SEQ_LAST    = 3'h5;
	typedef enum logic [1:0] {
		OP_READ   = 2'b00,
		OP_WRITE  = 2'b01,
		OP_STORE  = 2'b10,
		OP_RECALL = 2'b11
	} nvs_op_t;
endpackage

// ---- src/nvs_cyc_if.sv ----
// Carrier between the command sequencer and the pin cycle engine
interface nvs_cyc_if;
	logic        start;
	logic        is_write;
	logic        oe_en;
	logic [12:0] addr;
	logic [7:0]  wdata;
	logic [7:0]  rdata;
	logic        done;
	modport seq (output start, output is_write, output oe_en, output addr, output wdata,
		input rdata, input done);
	modport cyc (input start, input is_write, input oe_en, input addr, input wdata,
		output rdata, output done);
endinterface

// ---- src/nvs_cyc.sv ----
// One chip-select-controlled read or write cycle on the memory pins
module nvs_cyc (
	input  wire logic   i_core_clk,
	input  wire logic   i_sys_rst,
	nvs_cyc_if.cyc      cif,
	output logic [12:0] o_mem_addr,
	output logic        o_cs_n,
	output logic        o_dir_sel_n,
	output logic        o_oe_n,
	output logic [7:0]  o_dq_out,
	output logic        o_dq_oe,
	input  wire logic [7:0] i_dq_in
);
	typedef enum logic [1:0] {
		C_IDLE  = 2'b00,
		C_SETUP = 2'b01,
		C_STRB  = 2'b10,
		C_HOLD  = 2'b11
	} nvs_cst_t;

	nvs_cst_t   state;
	logic       wr;
	logic       oe_want;
	logic [4:0] cnt;
	logic [7:0] dq_s1;
	logic [7:0] dq_s2;
	logic [7:0] rdata;
	logic       done;

	wire [4:0] rd_len = 5'(nvs_pkg::RD_CYC + nvs_pkg::SYNC_CYC - 1);
	wire [4:0] wr_len = 5'(nvs_pkg::WR_CYC - 1);
	wire [4:0] len    = wr ? wr_len : rd_len;

	assign cif.rdata = rdata;
	assign cif.done  = done;

	always_ff @(posedge i_core_clk) begin
		dq_s1 <= i_dq_in;
		dq_s2 <= dq_s1;
	end

	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			state       <= C_IDLE;
			wr          <= 1'h0;
			oe_want     <= 1'h0;
			cnt         <= 5'h00;
			rdata       <= 8'h00;
			done        <= 1'h0;
			o_mem_addr  <= 13'h0000;
			o_cs_n      <= 1'h1;
			o_dir_sel_n <= 1'h1;
			o_oe_n      <= 1'h1;
			o_dq_out    <= 8'h00;
			o_dq_oe     <= 1'h0;
		end else begin
			done <= 1'h0;
			unique case (state)
				C_IDLE: if (cif.start) begin
					// address settles a cycle before the strobe
					o_mem_addr <= cif.addr;
					o_dq_out   <= cif.wdata;
					wr         <= cif.is_write;
					oe_want    <= cif.oe_en & ~cif.is_write;
					state      <= C_SETUP;
				end
				C_SETUP: begin
					// read or write strobes, output enable only on reads
					o_cs_n      <= 1'h0;
					o_dir_sel_n <= ~wr;
					o_oe_n      <= ~oe_want;
					o_dq_oe     <= wr;
					cnt         <= len;
					state       <= C_STRB;
				end
				C_STRB: if (cnt == 5'h00) begin
					// every access ends with chip select rising
					o_cs_n      <= 1'h1;
					o_dir_sel_n <= 1'h1;
					o_oe_n      <= 1'h1;
					rdata       <= dq_s2;
					state       <= C_HOLD;
				end else begin
					cnt <= cnt - 5'h01;
				end
				C_HOLD: begin
					// Data and address held one cycle past the end of write
					o_dq_oe <= 1'h0;
					done    <= 1'h1;
					state   <= C_IDLE;
				end
			endcase
		end
	end

	property p_read_strobes;
		@(posedge i_core_clk) disable iff (i_sys_rst)
		!o_oe_n |-> (o_dir_sel_n && !o_cs_n);
	endproperty
	a_read_strobes: assert property (p_read_strobes) else $error("oe low outside a read");

	property p_no_contend;
		@(posedge i_core_clk) disable iff (i_sys_rst)
		!o_dir_sel_n |-> (o_oe_n && o_dq_oe);
	endproperty
	a_no_contend: assert property (p_no_contend) else $error("oe low during write");

	property p_addr_stable;
		@(posedge i_core_clk) disable iff (i_sys_rst)
		(!o_dir_sel_n && !o_cs_n) |=> (o_dir_sel_n || $stable(o_mem_addr))
			and ($stable(o_mem_addr));
	endproperty
	a_addr_stable: assert property (p_addr_stable) else $error("address moved in write");

	property p_write_end;
		@(posedge i_core_clk) disable iff (i_sys_rst)
		$rose(o_dir_sel_n) |-> o_dq_oe && $stable(o_dq_out) ##1 !o_dq_oe;
	endproperty
	a_write_end: assert property (p_write_end) else $error("data not held at write end");

	logic [4:0] cs_low_cnt;
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst || o_cs_n)
			cs_low_cnt <= 5'h00;
		else
			cs_low_cnt <= cs_low_cnt + 5'h01;
	end

	property p_cs_pulse;
		@(posedge i_core_clk) disable iff (i_sys_rst)
		$rose(o_cs_n) |-> (cs_low_cnt == 5'(nvs_pkg::WR_CYC)
			|| cs_low_cnt == 5'(nvs_pkg::RD_CYC + nvs_pkg::SYNC_CYC));
	endproperty
	a_cs_pulse: assert property (p_cs_pulse) else $error("cs pulse length wrong");

	c_write: cover property (@(posedge i_core_clk) disable iff (i_sys_rst) $rose(o_dir_sel_n));
endmodule

// ---- sim/nvs_mem_model.sv ----
// Pin-level behavioural model of the nonvolatile SRAM device
module nvs_mem_model #(
	parameter int REST_T   = 20,
	parameter int STORE_T  = 40,
	parameter int RECALL_T = 30
) (
	input  wire logic        i_clk,
	input  wire logic        i_pwr_ok,
	input  wire logic        i_cs_n,
	input  wire logic        i_dir_sel_n,
	input  wire logic        i_oe_n,
	input  wire logic [12:0] i_addr,
	input  wire logic [7:0]  i_dq,
	output logic [7:0]       o_dq,
	output logic             o_dq_en,
	output int               o_viol
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [12:0] SEQ [5] = '{nvs_pkg::SEQ_A0, nvs_pkg::SEQ_A1, nvs_pkg::SEQ_A2,
		nvs_pkg::SEQ_A3, nvs_pkg::SEQ_A4};
	logic [7:0] mem [8192];
	logic [7:0] shadow [8192];
	int         busy = 0;
	logic       op_rec = 1'b0;
	logic       rec_req = 1'b1;
	logic [2:0] step = 3'h0;
	logic       cs_q = 1'b1;
	logic       dir_q = 1'b1;
	wire        rd_end = !cs_q && dir_q && i_cs_n;
	wire        wr_end = !cs_q && !dir_q && (i_cs_n || i_dir_sel_n);
	// drive only on a plain read
	assign o_dq_en = !i_cs_n && !i_oe_n && i_dir_sel_n && busy == 0 && i_pwr_ok;
	assign o_dq = mem[i_addr];
	initial begin
		o_viol = 0;
		for (int i = 0; i < 8192; i++) begin
			mem[i] = 8'h00;
			shadow[i] = 8'(i) ^ 8'h5a;
		end
	end
	always @(posedge i_clk) begin
		cs_q <= i_cs_n;
		dir_q <= i_dir_sel_n;
		if (!i_pwr_ok) begin
			rec_req <= 1'b1;
			step <= 3'h0;
			busy <= 0;
		end else if (rec_req) begin
			rec_req <= 1'b0;
			op_rec <= 1'b1;
			busy <= REST_T;
		end else if (busy > 0) begin
			if (!i_cs_n)
				o_viol <= o_viol + 1;
			busy <= busy - 1;
			for (int i = 0; i < 8192; i++) begin
				if (busy == 1 && op_rec)
					mem[i] <= shadow[i];
				if (busy == 1 && !op_rec)
					shadow[i] <= mem[i];
			end
		end else if (wr_end) begin
			mem[i_addr] <= i_dq;
			step <= 3'h0;
		end else if (rd_end) begin
			if (step == nvs_pkg::SEQ_LAST &&
				(i_addr == nvs_pkg::SEQ_STORE || i_addr == nvs_pkg::SEQ_RECALL)) begin
				op_rec <= !i_addr[0];
				busy <= i_addr[0] ? STORE_T : RECALL_T;
				step <= 3'h0;
			end else if (step < nvs_pkg::SEQ_LAST && i_addr == SEQ[step])
				step <= step + 3'h1;
			else
				step <= {2'b00, i_addr == nvs_pkg::SEQ_A0};
		end
	end
endmodule

// ---- sim/nvs_host_test.sv ----
// Self-checking bench for the nonvolatile SRAM host controller
module nvs_host_test;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int RS = 30;
	logic             clk = 1'b0;
	logic             rst, req, pwr_ok, ready, done, cs_n, dir_n, oe_n, dq_oe, m_en;
	nvs_pkg::nvs_op_t op;
	logic [12:0]      addr, m_addr;
	logic [7:0]       wdata, rdata, dq_out, dq_in, m_dq, lane_q;
	logic [7:0]       exp_mem [8192];
	logic [7:0]       exp_sh [8192];
	logic [12:0]      tad [8];
	logic [8:0]       notes [$];
	logic [8:0]       nt;
	int               fails = 0;
	int               num_checks = 0;
	int               viol;
	// Undriven lane shows the inverse of its last level
	assign dq_in = dq_oe ? dq_out : (m_en ? m_dq : ~lane_q);
	nvs_host #(.STORE_CYC(50), .RECALL_CYC(40), .RESTORE_CYC(RS)) dut (
		.i_core_clk(clk), .i_sys_rst(rst), .i_req(req), .i_op(op), .i_addr(addr),
		.i_wdata(wdata), .o_ready(ready), .o_done(done), .o_rdata(rdata),
		.o_mem_addr(m_addr), .o_cs_n(cs_n), .o_dir_sel_n(dir_n), .o_oe_n(oe_n),
		.o_dq_out(dq_out), .o_dq_oe(dq_oe), .i_dq_in(dq_in));
	nvs_mem_model mdl (
		.i_clk(clk), .i_pwr_ok(pwr_ok), .i_cs_n(cs_n), .i_dir_sel_n(dir_n),
		.i_oe_n(oe_n), .i_addr(m_addr), .i_dq(dq_in), .o_dq(m_dq), .o_dq_en(m_en),
		.o_viol(viol));
	initial begin
		forever #2 clk = ~clk;
	end
	always @(posedge clk) lane_q <= dq_in;
	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk_cnt(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic end_sim;
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic cmd(input nvs_pkg::nvs_op_t o, input logic [12:0] a, input logic [7:0] d,
		input logic [8:0] note);
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (ready !== 1'b1 && n < 4000);
		if (n >= 4000) begin
			fails++;
			end_sim;
		end
		notes.push_back(note);
		req <= 1'b1;
		op <= o;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		req <= 1'b0;
	endtask
	task automatic idle;
		int n;
		n = 0;
		while ((notes.size() != 0 || ready !== 1'b1) && n < 4000) begin
			@(posedge clk);
			n++;
		end
		if (n >= 4000) begin
			fails++;
			end_sim;
		end
	endtask
	task automatic wr(input logic [12:0] a, input logic [7:0] d);
		exp_mem[a] = d;
		cmd(nvs_pkg::OP_WRITE, a, d, 9'h000);
	endtask
	task automatic rd(input logic [12:0] a);
		cmd(nvs_pkg::OP_READ, a, 8'h00, {1'b1, exp_mem[a]});
	endtask
	task automatic nv(input nvs_pkg::nvs_op_t o, input logic eff);
		for (int i = 0; i < 8192; i++) begin
			if (eff && o == nvs_pkg::OP_STORE)
				exp_sh[i] = exp_mem[i];
			if (eff && o == nvs_pkg::OP_RECALL)
				exp_mem[i] = exp_sh[i];
		end
		cmd(o, 13'h0000, 8'h00, 9'h000);
	endtask
	always @(posedge clk) begin
		if (done === 1'b1) begin
			if (notes.size() == 0)
				chk_cnt(32'h0000_0000, 32'h0000_0001);
			else begin
				nt = notes.pop_front();
				if (nt[8])
					chk_byte(rdata, nt[7:0]);
			end
		end
	end
	initial begin
		int n;
		logic bad;
		{rst, req, pwr_ok, addr, wdata, lane_q, bad} = {3'b100, 13'h0000, 8'h00, 8'h00, 1'b0};
		op = nvs_pkg::OP_READ;
		n = $urandom(32'h0000_bc7e);
		for (int i = 0; i < 8192; i++) begin
			exp_mem[i] = 8'(i) ^ 8'h5a;
			exp_sh[i] = exp_mem[i];
		end
		for (int i = 0; i < 8; i++)
			tad[i] = (i == 0) ? 13'h0000 : (i == 1) ? 13'h1fff : 13'($urandom);
		@(posedge clk);
		pwr_ok <= 1'b1;
		repeat (15) @(posedge clk);
		rst <= 1'b0;
		n = 0;
		while (ready !== 1'b1 && n < 200) begin
			@(posedge clk);
			bad |= (cs_n !== 1'b1);
			n++;
		end
		if (n >= 200) begin
			fails++;
			end_sim;
		end
		chk_cnt(32'({n > RS, bad}), 32'h0000_0002);
		for (int i = 0; i < 8; i++) rd(tad[i]);
		for (int i = 0; i < 8; i++) wr(tad[i], 8'($urandom));
		for (int i = 0; i < 8; i++) rd(tad[i]);
		nv(nvs_pkg::OP_STORE, 1'b1);
		for (int i = 0; i < 8; i++) wr(tad[i], ~exp_mem[tad[i]]);
		// Interrupted trigger must leave the array alone
		rd(nvs_pkg::SEQ_A0);
		rd(nvs_pkg::SEQ_A1);
		rd(nvs_pkg::SEQ_A2);
		rd(nvs_pkg::SEQ_A3);
		rd(nvs_pkg::SEQ_A4);
		wr(nvs_pkg::SEQ_RECALL, 8'h3c);
		rd(nvs_pkg::SEQ_RECALL);
		for (int i = 0; i < 8; i++) rd(tad[i]);
		nv(nvs_pkg::OP_RECALL, 1'b1);
		for (int i = 0; i < 8; i++) rd(tad[i]);
		for (int i = 0; i < 8; i++) wr(tad[i], 8'($urandom));
		idle;
		pwr_ok <= 1'b0;
		nv(nvs_pkg::OP_STORE, 1'b0);
		idle;
		pwr_ok <= 1'b1;
		for (int i = 0; i < 8192; i++) exp_mem[i] = exp_sh[i];
		repeat (RS) @(posedge clk);
		for (int i = 0; i < 8; i++) rd(tad[i]);
		idle;
		chk_cnt(32'(viol), 32'h0000_0000);
		end_sim;
	end
endmodule
